// *** hdl/esp_params.svh ***
// Contract
// - any write of serial_buffer starts a transmission in every mode
// - async start bit accepted only with receive enabled and rx_done_flag clear
// - mode_sel_hi/lo pick sync8, async10 generator, async11 fixed, async11 generator
// - mode 0: data both ways on rx pin, shift clock always on tx pin
// - mode 0 shift clock is system/12, or system/4 when mp_qualify_bit set
// - mode 0 send starts next clock, shifts right on falling shift edge
// - after 8 mode 0 bits, send ends and tx_done_flag sets next clock
// - mode 0 receive starts with enable and flag clear, latches on rising edge
// - after 8 mode 0 bits, receive ends and rx_done_flag sets
// - mode 1 frame: start, 8 data lsb first, stop; stop goes to rx_ninth_bit
// - async send waits for next divide-by-16 rollover after the write
// - mode 1 sends start, data, stop; tx_done_flag set as stop goes out
// - receiver samples at 16x; falling edge resets the divide-by-16 counter
// - each bit sampled at states 7, 8, 9; majority of three wins
// - a start bit that is not 0 aborts reception and rearms
// - mode 1 frame stored only if flag clear and (qualify 0 or stop 1)
// - mode 2 frame: start, 8 data, ninth bit, stop; write copies tx_ninth_bit
// - mode 2 receive: ninth bit to rx_ninth_bit, stop discarded
// - mode 2 bit rate fixed at system/32 or system/64 via rate_double_bit
// - mode 2 send: start, 9 data, stop; tx_done_flag at eleventh rollover
// - mode 2 frame stored only if flag clear and (qualify 0 or ninth 1 and address match)
// - after each async frame receiver watches for falling edge again
// - rate_double_bit 0 gives system/64, 1 gives system/32; the code applies it in mode 2 only, modes 1 and 3 ignore it
// - given address compares only slave_addr bits where slave_addr_mask is 1
`ifndef ESP_PARAMS_SVH
`define ESP_PARAMS_SVH
`define ESP_OFS_BUFFER      4'h0
`define ESP_OFS_CONTROL     4'h4
`define ESP_OFS_POWER       4'h8
`define ESP_OFS_ADDR        4'hC
`define ESP_BIT_MODE_HI     7
`define ESP_BIT_MODE_LO     6
`define ESP_BIT_QUALIFY     5
`define ESP_BIT_RX_EN       4
`define ESP_BIT_TX_NINTH    3
`define ESP_BIT_RX_NINTH    2
`define ESP_BIT_TX_DONE     1
`define ESP_BIT_RX_DONE     0
`define ESP_BIT_RATE_DOUBLE 7
`define ESP_RST_CONTROL     8'h00
`define ESP_RST_BAUD        16'h0000
`define ESP_SYNC_DIV_SLOW   4'd12
`define ESP_SYNC_DIV_FAST   4'd4
`define ESP_FIX_DIV_SLOW    7'd4
`define ESP_FIX_DIV_FAST    7'd2
`define ESP_BAUD_TOP        15'h7fff
`endif

// *** hdl/esp_pkg.sv ***
package esp_pkg;
  typedef enum logic [1:0] {
    ESP_M_SYNC,
    ESP_M_ASYNC10,
    ESP_M_FIXED11,
    ESP_M_VAR11
  } esp_mode_e;
  typedef enum logic [1:0] {
    ESP_RX_IDLE,
    ESP_RX_SHIFT,
    ESP_RX_SYNC
  } esp_rx_e;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } esp_bus_s;
endpackage

// *** hdl/esp_top.sv ***
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "esp_params.svh"
module esp_top (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire esp_pkg::esp_bus_s avs,
  output logic                  avs_waitrequest,
  output logic [31:0]           avs_readdata,
  input  wire logic             rx_pin_in,
  output logic                  rx_pin_out,
  output logic                  rx_pin_oe_n,
  output logic                  tx_pin_out
);
  // registers
  logic [7:0]  serial_control_q;
  logic [7:0]  serial_buffer_q;
  logic        rate_double_bit_q;
  logic [7:0]  slave_addr_q;
  logic [7:0]  slave_addr_mask_q;
  logic [15:0] baud_reload_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  // tx state
  logic        tx_busy_q;
  logic        tx_armed_q;
  logic [10:0] tx_shift_q;
  logic [3:0]  tx_bits_q;
  // rx state
  esp_pkg::esp_rx_e rx_state_q;
  logic [9:0]  rx_shift_q;
  logic [3:0]  rx_bits_q;
  logic [2:0]  votes_q;
  logic        rx_last_q;
  // timing
  logic [3:0]  sync_cnt_q;
  logic        sclk_q;
  logic [14:0] baud_cnt_q;
  logic [6:0]  fix_cnt_q;
  logic [3:0]  tx_div_q;
  logic [3:0]  rx_div_q;
  logic        wr_buf;
  logic        wr_ctl;
  logic        tick16;
  logic        tx_roll;
  logic        rx_tick;
  logic        sclk_fall;
  logic        sclk_rise;
  logic        frame_end;
  logic        store_ok;
  logic        rx_bit;
  logic [3:0]  sync_div;
  logic [3:0]  sync_half;
  esp_pkg::esp_mode_e mode;
  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  function automatic logic addr_match(input logic [7:0] b, input logic [7:0] a,
                                      input logic [7:0] m);
    addr_match = ((b ^ a) & m) == 8'h00;
  endfunction
  assign mode = esp_pkg::esp_mode_e'({serial_control_q[`ESP_BIT_MODE_HI],
                                      serial_control_q[`ESP_BIT_MODE_LO]});
  // writes land on the edge where waitrequest is low
  assign wr_buf = avs.write & ack_q & (avs.address == `ESP_OFS_BUFFER);
  assign wr_ctl = avs.write & ack_q & (avs.address == `ESP_OFS_CONTROL);
  assign sync_div = serial_control_q[`ESP_BIT_QUALIFY] ? `ESP_SYNC_DIV_FAST
                                                        : `ESP_SYNC_DIV_SLOW;
  assign sync_half = sync_div >> 1;
  // fixed rate: 16 ticks of 2 or 4 clocks each
  assign tick16 = (mode == esp_pkg::ESP_M_FIXED11)
                ? (fix_cnt_q == (rate_double_bit_q ? `ESP_FIX_DIV_FAST : `ESP_FIX_DIV_SLOW)
                   - 7'd1)
                : (baud_cnt_q == `ESP_BAUD_TOP);
  assign tx_roll = tick16 & (tx_div_q == 4'hf);
  assign rx_tick = tick16 & (rx_div_q == 4'hf);
  assign sclk_fall = (sync_cnt_q == sync_half - 4'd1) & sclk_q;
  assign sclk_rise = (sync_cnt_q == sync_half - 4'd1) & ~sclk_q;
  assign rx_bit = majority(votes_q);
  assign frame_end = (rx_state_q == esp_pkg::ESP_RX_SHIFT) & rx_tick
                   & (rx_bits_q == ((mode == esp_pkg::ESP_M_ASYNC10) ? 4'd9 : 4'd10));
  assign store_ok = ~serial_control_q[`ESP_BIT_RX_DONE]
                  & (~serial_control_q[`ESP_BIT_QUALIFY]
                     | ((mode == esp_pkg::ESP_M_ASYNC10) ? rx_bit
                        : (rx_shift_q[9] & addr_match(rx_shift_q[8:1], slave_addr_q,
                                                     slave_addr_mask_q))));
  // bus slave: one wait cycle, then answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs.read | avs.write) & ~ack_q;
    end
  end
  assign avs_waitrequest = ~ack_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs.read) begin
      case (avs.address)
        `ESP_OFS_BUFFER:  rdata_q <= {24'h00_0000, serial_buffer_q};
        `ESP_OFS_CONTROL: rdata_q <= {24'h00_0000, serial_control_q};
        `ESP_OFS_POWER:   rdata_q <= {24'h00_0000, rate_double_bit_q, 7'h00};
        `ESP_OFS_ADDR:    rdata_q <= {16'h0000, slave_addr_mask_q, slave_addr_q};
        default:          rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rate_double_bit_q <= 1'b0;
      slave_addr_q      <= 8'h00;
      slave_addr_mask_q <= 8'h00;
      baud_reload_q     <= `ESP_RST_BAUD;
    end else if (avs.write & ack_q) begin
      if (avs.address == `ESP_OFS_POWER) begin
        rate_double_bit_q <= avs.writedata[`ESP_BIT_RATE_DOUBLE];
        baud_reload_q     <= avs.writedata[31:16];
      end
      if (avs.address == `ESP_OFS_ADDR) begin
        slave_addr_q      <= avs.writedata[7:0];
        slave_addr_mask_q <= avs.writedata[15:8];
      end
    end
  end
  // control: hardware sets win over software clears
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serial_control_q <= `ESP_RST_CONTROL;
    end else begin
      if (wr_ctl) begin
        serial_control_q <= avs.writedata[7:0];
      end
      if ((tx_busy_q & (mode == esp_pkg::ESP_M_SYNC) & sclk_fall & tx_bits_q == 4'd8)
          | (tx_busy_q & tx_armed_q & (mode != esp_pkg::ESP_M_SYNC) & tx_roll & tx_bits_q ==
             ((mode == esp_pkg::ESP_M_ASYNC10) ? 4'd8 : 4'd9))) begin
        serial_control_q[`ESP_BIT_TX_DONE] <= 1'b1;
      end
      if ((rx_state_q == esp_pkg::ESP_RX_SYNC) & sclk_rise & rx_bits_q == 4'd7) begin
        serial_control_q[`ESP_BIT_RX_DONE] <= 1'b1;
      end
      if (frame_end & store_ok) begin
        serial_control_q[`ESP_BIT_RX_DONE] <= 1'b1;
        serial_control_q[`ESP_BIT_RX_NINTH] <=
          (mode == esp_pkg::ESP_M_ASYNC10) ? rx_bit : rx_shift_q[9];
      end
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serial_buffer_q <= 8'h00;
    end else if ((rx_state_q == esp_pkg::ESP_RX_SYNC) & sclk_rise & rx_bits_q == 4'd7) begin
      serial_buffer_q <= {rx_pin_in, rx_shift_q[9:3]};
    end else if (frame_end & store_ok) begin
      serial_buffer_q <= (mode == esp_pkg::ESP_M_ASYNC10) ? rx_shift_q[9:2] : rx_shift_q[8:1];
    end
  end
  // baud generator and fixed prescaler
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      baud_cnt_q <= 15'h0000;
      fix_cnt_q  <= 7'h00;
    end else begin
      baud_cnt_q <= (baud_cnt_q == `ESP_BAUD_TOP) ? baud_reload_q[14:0] : baud_cnt_q + 15'd1;
      fix_cnt_q  <= tick16 ? 7'h00 : fix_cnt_q + 7'd1;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_cnt_q <= 4'h0;
      sclk_q     <= 1'b1;
    end else if (tx_busy_q | (rx_state_q == esp_pkg::ESP_RX_SYNC)) begin
      // equal halves; clock stays high once the last bit is done
      if (sync_cnt_q == sync_half - 4'd1) begin
        sync_cnt_q <= 4'h0;
        sclk_q     <= ~sclk_q | (tx_busy_q & (tx_bits_q == 4'd8));
      end else begin
        sync_cnt_q <= sync_cnt_q + 4'd1;
      end
    end else begin
      sync_cnt_q <= 4'h0;
      sclk_q     <= 1'b1;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_div_q <= 4'h0;
    end else if (tick16) begin
      tx_div_q <= tx_div_q + 4'd1;
    end
  end
  // transmitter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_busy_q  <= 1'b0;
      tx_armed_q <= 1'b0;
      tx_shift_q <= 11'h7ff;
      tx_bits_q  <= 4'h0;
    end else if (wr_buf) begin
      tx_busy_q  <= 1'b1;
      tx_armed_q <= 1'b0;
      tx_bits_q  <= 4'h0;
      if (mode == esp_pkg::ESP_M_SYNC) begin
        tx_shift_q <= {3'b000, avs.writedata[7:0]};
      end else if (mode == esp_pkg::ESP_M_ASYNC10) begin
        tx_shift_q <= {2'b11, avs.writedata[7:0], 1'b0};
      end else begin
        tx_shift_q <= {1'b1, serial_control_q[`ESP_BIT_TX_NINTH], avs.writedata[7:0], 1'b0};
      end
    end else if (tx_busy_q & (mode == esp_pkg::ESP_M_SYNC)) begin
      // shift right, zero fill
      // first fall only opens the frame; bit 0 already stands
      if (sclk_fall) begin
        if (tx_bits_q != 4'd0) begin
          tx_shift_q <= {1'b0, tx_shift_q[10:1]};
        end
        tx_bits_q  <= tx_bits_q + 4'd1;
        if (tx_bits_q == 4'd8) begin
          tx_busy_q <= 1'b0;
        end
      end
    end else if (tx_busy_q & tx_roll) begin
      // first rollover arms, later ones shift
      if (!tx_armed_q) begin
        tx_armed_q <= 1'b1;
      end else begin
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_bits_q  <= tx_bits_q + 4'd1;
        if (tx_bits_q == ((mode == esp_pkg::ESP_M_ASYNC10) ? 4'd9 : 4'd10)) begin
          tx_busy_q  <= 1'b0;
          tx_armed_q <= 1'b0;
        end
      end
    end
  end
  // pins: clock on tx in mode 0, data on rx
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_pin_out  <= 1'b1;
      rx_pin_out  <= 1'b1;
      rx_pin_oe_n <= 1'b1;
    end else if (mode == esp_pkg::ESP_M_SYNC) begin
      tx_pin_out  <= sclk_q;
      rx_pin_out  <= tx_shift_q[0];
      rx_pin_oe_n <= ~tx_busy_q;
    end else begin
      tx_pin_out  <= tx_armed_q ? tx_shift_q[0] : 1'b1;
      rx_pin_out  <= 1'b1;
      rx_pin_oe_n <= 1'b1;
    end
  end
  // receiver
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_state_q <= esp_pkg::ESP_RX_IDLE;
      rx_shift_q <= 10'h000;
      rx_bits_q  <= 4'h0;
      rx_div_q   <= 4'h0;
      votes_q    <= 3'b111;
      rx_last_q  <= 1'b1;
    end else begin
      rx_last_q <= rx_pin_in;
      if (tick16) begin
        rx_div_q <= rx_div_q + 4'd1;
      end
      case (rx_state_q)
        esp_pkg::ESP_RX_IDLE: begin
          rx_bits_q <= 4'h0;
          if ((mode == esp_pkg::ESP_M_SYNC) & serial_control_q[`ESP_BIT_RX_EN]
              & ~serial_control_q[`ESP_BIT_RX_DONE] & ~tx_busy_q) begin
            rx_state_q <= esp_pkg::ESP_RX_SYNC;
          end else if ((mode != esp_pkg::ESP_M_SYNC) & serial_control_q[`ESP_BIT_RX_EN]
                       & ~serial_control_q[`ESP_BIT_RX_DONE] & rx_last_q & ~rx_pin_in) begin
            rx_state_q <= esp_pkg::ESP_RX_SHIFT;
            rx_div_q   <= 4'h0;
          end
        end
        esp_pkg::ESP_RX_SYNC: begin
          // latch on rising edge, shift right
          if (sclk_rise) begin
            rx_shift_q <= {rx_pin_in, rx_shift_q[9:1]};
            rx_bits_q  <= rx_bits_q + 4'd1;
            if (rx_bits_q == 4'd7) begin
              rx_state_q <= esp_pkg::ESP_RX_IDLE;
            end
          end
        end
        esp_pkg::ESP_RX_SHIFT: begin
          // samples at states 7, 8, 9
          if (tick16 & (rx_div_q >= 4'd6) & (rx_div_q <= 4'd8)) begin
            votes_q <= {votes_q[1:0], rx_pin_in};
          end
          if (rx_tick) begin
            rx_bits_q <= rx_bits_q + 4'd1;
            if ((rx_bits_q == 4'h0) & rx_bit) begin
              rx_state_q <= esp_pkg::ESP_RX_IDLE;
            end else if (frame_end) begin
              rx_state_q <= esp_pkg::ESP_RX_IDLE;
            end else if (rx_bits_q != 4'h0) begin
              rx_shift_q <= {rx_bit, rx_shift_q[9:1]};
            end
          end
        end
        default: rx_state_q <= esp_pkg::ESP_RX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** sim/esp_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module esp_props (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire esp_pkg::esp_bus_s avs,
  input wire logic              avs_waitrequest,
  input wire logic [31:0]       avs_readdata,
  input wire logic              rx_pin_out,
  input wire logic              rx_pin_oe_n,
  input wire logic              tx_pin_out
);
  logic req;
  assign req = avs.read | avs.write;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer missing");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  ack_cause_a: assert property (!avs_waitrequest |-> $past(req))
    else $error("answer without request");
  unmapped_zero_a: assert property (!avs_waitrequest && avs.read && avs.address[1:0] != 2'b00
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!avs.read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  idle_high_a: assert property ($fell(rst) |-> tx_pin_out && rx_pin_oe_n)
    else $error("pins not idle after reset");
  sclk_runs_a: assert property ($fell(rx_pin_oe_n) |-> ##[1:40] $fell(tx_pin_out))
    else $error("no shift clock while sending");
  shift_fall_a: assert property (!rx_pin_oe_n && $past(!rx_pin_oe_n) && $changed(rx_pin_out)
    |-> ##[0:1] !tx_pin_out) else $error("data moved in clock high phase");
endmodule
bind esp_top esp_props u_props (
  .core_clk(core_clk), .rst(rst), .avs(avs), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .rx_pin_out(rx_pin_out), .rx_pin_oe_n(rx_pin_oe_n),
  .tx_pin_out(tx_pin_out)
);
`default_nettype wire

// *** sim/esp_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module esp_peer (
  input  wire logic        core_clk,
  input  wire logic        sclk,
  input  wire logic        go,
  input  wire logic        sync_en,
  input  wire logic [10:0] frame,
  input  wire logic [7:0]  bit_cyc,
  output logic             line
);
  logic [11:0] sh_q;
  logic [7:0]  cnt_q;
  logic        sclk_q;
  initial begin
    sh_q = '1;
    cnt_q = 8'h00;
    sclk_q = 1'b1;
  end
  always_ff @(posedge core_clk) begin
    sclk_q <= sclk;
    if (go) begin
      sh_q <= {1'b1, frame};
      cnt_q <= 8'h00;
    end else if (sync_en) begin
      // next bit once the device has latched on the rising clock
      if (!sclk_q && sclk) sh_q <= {1'b1, sh_q[11:1]};
    end else if (cnt_q == bit_cyc - 8'h01) begin
      // start bit first, line back to idle high
      sh_q <= {1'b1, sh_q[11:1]};
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign line = sh_q[0];
endmodule
`default_nettype wire

// *** sim/esp_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "esp_params.svh"
module esp_tb_top;
  logic              core_clk;
  logic              rst;
  esp_pkg::esp_bus_s avs;
  logic              avs_waitrequest;
  logic [31:0]       avs_readdata;
  logic              rx_pin_out;
  logic              rx_pin_oe_n;
  logic              tx_pin_out;
  logic              peer_line;
  logic              rx_line;
  logic              go;
  logic              sync_en;
  logic [10:0]       frame;
  logic [7:0]        bit_cyc;
  logic [31:0]       rv;
  logic [10:0]       cap;
  logic [7:0]        b;
  logic              n9;
  int                per;
  int                err_count;
  int                check_count;
  assign rx_line = rx_pin_oe_n ? peer_line : rx_pin_out;
  esp_top dut (.core_clk(core_clk), .rst(rst), .avs(avs), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .rx_pin_in(rx_line), .rx_pin_out(rx_pin_out),
    .rx_pin_oe_n(rx_pin_oe_n), .tx_pin_out(tx_pin_out));
  esp_peer peer (.core_clk(core_clk), .sclk(tx_pin_out), .go(go), .sync_en(sync_en),
    .frame(frame), .bit_cyc(bit_cyc), .line(peer_line));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs <= {!wr, wr, a, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rv = avs_readdata;
    avs <= '0;
    @(posedge core_clk);
    if (n >= 100) chk("bus answer", 0, 1);
  endtask
  task automatic grab(input int per_c);
    int n;
    n = 0;
    while (tx_pin_out !== 1'b0 && n < 40000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (per_c / 2) @(posedge core_clk);
    for (int i = 0; i < 11; i++) begin
      cap[i] = tx_pin_out;
      repeat (per_c) @(posedge core_clk);
    end
  endtask
  task automatic grab0;
    real t0;
    t0 = 0.0;
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_pin_out);
      cap[i] = rx_line;
      if (i == 1) per = int'(($realtime - t0) / 5.0);
      t0 = $realtime;
    end
    repeat (20) @(posedge core_clk);
  endtask
  task automatic send(input logic [10:0] f, input logic [7:0] bc);
    frame <= f;
    bit_cyc <= bc;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (12 * bc) @(posedge core_clk);
  endtask
  function automatic logic [10:0] fr(input int m, input logic [7:0] d, input logic p);
    return (m == 1) ? {2'b11, d, 1'b0} : {1'b1, p, d, 1'b0};
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #450_000;
    err_count++;
    summarize;
  end
  initial begin
    err_count = 0;
    check_count = 0;
    rst = 1'b1;
    avs = '0;
    go = 1'b0;
    sync_en = 1'b0;
    frame = '1;
    bit_cyc = 8'd32;
    rv = $urandom(32'hb416_33ae);
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(0, 4'h4, 0);
    chk("control reset", `ESP_RST_CONTROL, rv);
    bus(1, 4'h6, $urandom);
    bus(0, 4'h6, 0);
    chk("unmapped read", 0, rv);
    $display("register test done");
    for (int m = 1; m < 4; m++) begin
      b = $urandom;
      n9 = $urandom;
      bus(1, 4'h8, 32'h7ffe_0080);
      bus(1, 4'h4, {24'h0, m[1:0], 2'b00, n9, 3'b000});
      bus(1, 4'h0, {24'h0, b});
      grab(32);
      chk("tx frame", fr(m, b, n9), cap);
      bus(0, 4'h4, 0);
      chk("tx done", 1, rv[1]);
      repeat (60) @(posedge core_clk);
      bus(0, 4'h4, 0);
      chk("tx done held", 1, rv[1]);
      bus(1, 4'h8, 32'h7ffe_0000);
      bus(1, 4'h4, {24'h0, m[1:0], 2'b01, 4'h0});
      send(fr(m, b, n9), (m == 2) ? 8'd64 : 8'd32);
      bus(0, 4'h4, 0);
      chk("rx done", 1, rv[0]);
      chk("rx ninth", (m == 1) ? 1'b1 : n9, rv[2]);
      bus(0, 4'h0, 0);
      chk("rx data", b, rv[7:0]);
      send(fr(m, ~b, n9), (m == 2) ? 8'd64 : 8'd32);
      bus(0, 4'h0, 0);
      chk("rx blocked", b, rv[7:0]);
      bus(1, 4'h4, 0);
      $display("async mode %0d test done", m);
    end
    b = $urandom;
    bus(1, 4'hC, {16'h0, 8'hf0, b});
    for (int k = 0; k < 4; k++) begin
      bus(1, 4'h4, (k == 0) ? 32'h70 : 32'hb0);
      send((k == 0) ? {2'b10, b, 1'b0}
                    : {1'b1, k != 1, b ^ ((k == 2) ? 8'h10 : 8'h0f), 1'b0},
           (k == 0) ? 8'd32 : 8'd64);
      bus(0, 4'h4, 0);
      chk("qualified store", k == 3, rv[0]);
      bus(0, 4'h0, 0);
      if (k == 3) chk("address byte", b ^ 8'h0f, rv[7:0]);
      bus(1, 4'h4, 0);
    end
    $display("address test done");
    for (int q = 0; q < 2; q++) begin
      b = $urandom;
      bus(1, 4'h4, {26'h0, q[0], 5'h00});
      bus(1, 4'h0, {24'h0, b});
      grab0;
      chk("sync tx data", b, cap[7:0]);
      chk("sync clock", (q == 1) ? 4 : 12, per);
      bus(0, 4'h4, 0);
      chk("sync tx done", 1, rv[1]);
      b = $urandom;
      frame <= {3'b111, b};
      go <= 1'b1;
      sync_en <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      bus(1, 4'h4, {26'h0, q[0], 5'h10});
      grab0;
      sync_en <= 1'b0;
      bus(0, 4'h4, 0);
      chk("sync rx done", 1, rv[0]);
      bus(0, 4'h0, 0);
      chk("sync rx data", b, rv[7:0]);
      bus(1, 4'h4, 0);
      $display("sync test %0d done", q);
    end
    summarize;
  end
endmodule
`default_nettype wire
